// [core/sdsi_ctrl.v]
`timescale 1ns/1ps
`include "sdsi_regs.vh"
module sdsi_ctrl (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_req,
    input wire i_mode_req,
    input wire i_mode_ext,
    input wire i_we,
    input wire [1:0] i_size,
    input wire [28:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_sdram_area2,
    input wire i_sdram_area3,
    input wire [6:0] i_bus16,
    input wire [27:0] i_wait,
    input wire [2:0] i_idle_rws,
    input wire [2:0] i_idle_rwd,
    input wire [2:0] i_idle_rrs,
    input wire [2:0] i_idle_rrd,
    input wire [2:0] i_idle_wr,
    input wire [1:0] i_row_sel,
    input wire [1:0] i_col_sel,
    input wire i_bank_active,
    input wire i_refresh_en,
    input wire i_self_refresh,
    input wire [15:0] i_ref_interval,
    input wire [3:0] i_trp,
    input wire [3:0] i_trc,
    input wire [3:0] i_trcd,
    input wire [3:0] i_cas_lat,
    input wire i_low_freq,
    input wire i_power_down,
    input wire [15:0] i_dq,
    output reg [31:0] o_rdata,
    output reg o_done,
    output reg o_busy,
    output reg [6:0] o_cs_n,
    output reg o_ras_n,
    output reg o_cas_n,
    output reg o_we_n,
    output reg o_cke,
    output reg [12:0] o_addr,
    output reg [1:0] o_ba,
    output reg [15:0] o_dq,
    output reg o_dq_oe_n,
    output reg [1:0] o_dqm
);
    localparam S_IDLE = 4'h0;
    localparam S_WAIT = 4'h1;
    localparam S_BEAT = 4'h2;
    localparam S_NRM = 4'h3;
    localparam S_RW = 4'h4;
    localparam S_CAP = 4'h5;
    localparam S_END = 4'h6;
    localparam S_PRECHARGE_ALL_CMD = 4'h7;
    localparam S_REF = 4'h8;
    localparam S_MRS = 4'h9;
    localparam S_SREF = 4'ha;
    localparam S_SELF = 4'hb;
    localparam S_FIN = 4'hc;

    reg [3:0] state_q;
    reg [3:0] nxt_q;
    reg [3:0] after_precharge_all_cmd_q;
    reg [3:0] wcnt_q;
    reg [3:0] mcnt_q;
    reg [2:0] sp_q;
    reg [25:0] a_q;
    reg we_q;
    reg [1:0] sz_q;
    reg [31:0] wsh_q;
    reg [2:0] beats_q;
    reg mext_q;
    reg minit_q;
    reg dflag_q;
    reg prev_v_q;
    reg [2:0] last_sp_q;
    reg last_we_q;
    reg open_q;
    reg [1:0] open_bank_q;
    reg [12:0] open_row_q;
    reg [15:0] rcnt_q;
    reg rpend_q;

    wire [6:0] sd_mask = {3'h0, i_sdram_area3, i_sdram_area2, 2'h0};
    wire sd_any = i_sdram_area2 | i_sdram_area3;
    wire [6:0] sp_hot = 7'h01 << sp_q;
    wire w16 = (sp_q == `SDSI_SP_BOOT) | i_bus16[sp_q];
    wire is_sd = ((sp_q == `SDSI_SP_AREA3) & i_sdram_area3)
               | ((sp_q == `SDSI_SP_AREA2) & i_sdram_area2);
    wire bact = i_bank_active & (sp_q == `SDSI_SP_AREA3);
    wire wide = w16 & (sz_q != `SDSI_SZ_BYTE);
    wire [25:0] wa = w16 ? {1'b0, a_q[25:1]} : a_q;
    wire [12:0] row = row_of(wa);
    wire [1:0] bank = bank_of(wa);
    wire [7:0] lane = (w16 & ~a_q[0]) ? i_dq[15:8] : i_dq[7:0];

    // row sits above the column bits, bank above the row bits
    function [12:0] row_of;
        input [25:0] w;
        reg [25:0] t;
        begin
            t = w >> (`SDSI_COL_MIN + {3'h0, i_col_sel});
            row_of = t[12:0] & ~(13'h1fff << (`SDSI_ROW_MIN + {3'h0, i_row_sel}));
        end
    endfunction

    function [1:0] bank_of;
        input [25:0] w;
        reg [25:0] t;
        begin
            t = w >> (`SDSI_COL_MIN + `SDSI_ROW_MIN + {3'h0, i_col_sel}
                + {3'h0, i_row_sel});
            bank_of = t[1:0];
        end
    endfunction

    function [9:0] col_of;
        input [25:0] w;
        begin
            col_of = w[9:0] & ~(10'h3ff << (`SDSI_COL_MIN + {3'h0, i_col_sel}));
        end
    endfunction

    function [2:0] gap_of;
        input [2:0] sp;
        input we;
        begin
            if (last_we_q)
                gap_of = i_idle_wr;
            else if (we)
                gap_of = (sp == last_sp_q) ? i_idle_rws : i_idle_rwd;
            else
                gap_of = (sp == last_sp_q) ? i_idle_rrs : i_idle_rrd;
        end
    endfunction

    task issue;
        input [6:0] csm;
        input [2:0] c;
        begin
            o_cs_n <= ~csm;
            o_ras_n <= c[2];
            o_cas_n <= c[1];
            o_we_n <= c[0];
        end
    endtask

    task go;
        input [3:0] n;
        input [3:0] s;
        begin
            if (n == 4'h0) begin
                state_q <= s;
            end else begin
                state_q <= S_WAIT;
                wcnt_q <= n;
                nxt_q <= s;
            end
        end
    endtask

    always @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= S_IDLE;
            nxt_q <= S_IDLE;
            after_precharge_all_cmd_q <= S_IDLE;
            wcnt_q <= 4'h0;
            mcnt_q <= 4'h0;
            sp_q <= 3'h0;
            a_q <= 26'h000_0000;
            we_q <= 1'b0;
            sz_q <= 2'h0;
            wsh_q <= 32'h0000_0000;
            beats_q <= 3'h0;
            mext_q <= 1'b0;
            minit_q <= 1'b0;
            dflag_q <= 1'b0;
            prev_v_q <= 1'b0;
            last_sp_q <= 3'h0;
            last_we_q <= 1'b0;
            open_q <= 1'b0;
            open_bank_q <= 2'h0;
            open_row_q <= 13'h0000;
            rcnt_q <= 16'h0000;
            rpend_q <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_done <= 1'b0;
            o_busy <= 1'b0;
            o_cs_n <= 7'h7f;
            o_ras_n <= 1'b1;
            o_cas_n <= 1'b1;
            o_we_n <= 1'b1;
            o_cke <= 1'b1;
            o_addr <= 13'h0000;
            o_ba <= 2'h0;
            o_dq <= 16'h0000;
            o_dq_oe_n <= 1'b1;
            o_dqm <= 2'h3;
        end else if (i_ce) begin
            o_done <= 1'b0;
            o_cs_n <= 7'h7f;
            o_ras_n <= 1'b1;
            o_cas_n <= 1'b1;
            o_we_n <= 1'b1;
            o_dq_oe_n <= 1'b1;
            if (i_refresh_en && sd_any && state_q != S_SELF) begin
                if (rcnt_q == 16'h0000) begin
                    rcnt_q <= i_ref_interval;
                    rpend_q <= 1'b1;
                end else begin
                    rcnt_q <= rcnt_q - 16'h0001;
                end
            end
            case (state_q)
                S_IDLE: begin
                    minit_q <= 1'b0;
                    if (i_mode_req) begin
                        // write data is dropped, only the address counts
                        sp_q <= i_addr[28:26];
                        a_q <= i_addr[25:0];
                        mext_q <= i_mode_ext;
                        minit_q <= 1'b1;
                        mcnt_q <= `SDSI_INIT_REFS;
                        dflag_q <= 1'b1;
                        o_busy <= 1'b1;
                        o_cke <= 1'b1;
                        after_precharge_all_cmd_q <= S_REF;
                        state_q <= S_PRECHARGE_ALL_CMD;
                    end else if (i_req) begin
                        sp_q <= i_addr[28:26];
                        a_q <= i_addr[25:0];
                        we_q <= i_we;
                        sz_q <= i_size;
                        // read data is right aligned, stale upper bits cleared
                        if (!i_we)
                            o_rdata <= 32'h0000_0000;
                        dflag_q <= 1'b1;
                        o_busy <= 1'b1;
                        o_cke <= 1'b1;
                        if (i_size == `SDSI_SZ_LONG)
                            wsh_q <= i_wdata;
                        else if (i_size == `SDSI_SZ_WORD)
                            wsh_q <= {i_wdata[15:0], 16'h0000};
                        else
                            wsh_q <= {i_wdata[7:0], 24'h00_0000};
                        go(prev_v_q ? {1'b0, gap_of(i_addr[28:26], i_we)} : 4'h0,
                            S_BEAT);
                    end else if (rpend_q || (i_self_refresh && sd_any)) begin
                        dflag_q <= 1'b0;
                        o_busy <= 1'b1;
                        o_cke <= 1'b1;
                        after_precharge_all_cmd_q <= rpend_q ? S_REF : S_SREF;
                        state_q <= S_PRECHARGE_ALL_CMD;
                    end else begin
                        o_cke <= ~(i_power_down & sd_any);
                    end
                end
                S_WAIT: begin
                    if (wcnt_q <= 4'h1)
                        state_q <= nxt_q;
                    else
                        wcnt_q <= wcnt_q - 4'h1;
                end
                S_PRECHARGE_ALL_CMD: begin
                    issue(sd_mask, `SDSI_CMD_PRE);
                    o_addr <= 13'h0400;
                    open_q <= 1'b0;
                    go(i_trp, after_precharge_all_cmd_q);
                end
                S_REF: begin
                    issue(sd_mask, `SDSI_CMD_REF);
                    rpend_q <= (i_refresh_en && rcnt_q == 16'h0000);
                    if (minit_q) begin
                        mcnt_q <= mcnt_q - 4'h1;
                        go(i_trc, (mcnt_q > 4'h1) ? S_REF : S_MRS);
                    end else begin
                        go(i_trc, S_FIN);
                    end
                end
                S_MRS: begin
                    // mode value comes from the low access address bits
                    issue(sp_hot, `SDSI_CMD_MRS);
                    o_addr <= {1'b0, a_q[11:0]};
                    o_ba <= mext_q ? `SDSI_EMRS_BA : `SDSI_MRS_BA;
                    go(i_trc, S_FIN);
                end
                S_SREF: begin
                    issue(sd_mask, `SDSI_CMD_REF);
                    o_cke <= 1'b0;
                    state_q <= S_SELF;
                end
                S_SELF: begin
                    if (!i_self_refresh) begin
                        o_cke <= 1'b1;
                        rcnt_q <= i_ref_interval;
                        go(i_trc, S_FIN);
                    end
                end
                S_BEAT: begin
                    o_dq <= wide ? wsh_q[31:16] : {wsh_q[31:24], wsh_q[31:24]};
                    o_dqm <= wide ? 2'h0 : (!w16 ? 2'h2 : (a_q[0] ? 2'h2 : 2'h1));
                    if (sp_q == `SDSI_SP_NONE) begin
                        state_q <= S_FIN;
                    end else if (!is_sd) begin
                        issue(sp_hot, we_q ? `SDSI_CMD_NWR : `SDSI_CMD_NRD);
                        o_addr <= a_q[12:0];
                        o_dq_oe_n <= ~we_q;
                        wcnt_q <= i_wait[{sp_q, 2'h0} +: 4];
                        state_q <= S_NRM;
                    end else if (bact && open_q && open_bank_q == bank
                            && open_row_q == row) begin
                        state_q <= S_RW;
                    end else if (bact && open_q) begin
                        after_precharge_all_cmd_q <= S_BEAT;
                        state_q <= S_PRECHARGE_ALL_CMD;
                    end else begin
                        issue(sp_hot, `SDSI_CMD_ACT);
                        o_addr <= row;
                        o_ba <= bank;
                        open_q <= bact;
                        open_bank_q <= bank;
                        open_row_q <= row;
                        go(i_trcd, S_RW);
                    end
                end
                S_NRM: begin
                    // strobe ends with the cycle in which the data is taken
                    if (wcnt_q == 4'h0) begin
                        if (!we_q)
                            o_rdata <= wide ? {o_rdata[15:0], i_dq}
                                : {o_rdata[23:0], lane};
                        state_q <= S_END;
                    end else begin
                        issue(sp_hot, we_q ? `SDSI_CMD_NWR : `SDSI_CMD_NRD);
                        o_dq_oe_n <= ~we_q;
                        wcnt_q <= wcnt_q - 4'h1;
                    end
                end
                S_RW: begin
                    issue(sp_hot, we_q ? `SDSI_CMD_WR : `SDSI_CMD_RD);
                    o_addr <= {2'h0, ~bact, col_of(wa)};
                    o_ba <= bank;
                    o_dq_oe_n <= ~we_q;
                    if (we_q)
                        go(bact ? 4'h0 : i_trp, S_END);
                    else
                        go((i_low_freq && i_cas_lat != 4'h0) ? i_cas_lat - 4'h1
                            : i_cas_lat, S_CAP);
                end
                S_CAP: begin
                    o_rdata <= wide ? {o_rdata[15:0], i_dq} : {o_rdata[23:0], lane};
                    go(bact ? 4'h0 : i_trp, S_END);
                end
                S_END: begin
                    wsh_q <= wide ? {wsh_q[15:0], 16'h0000} : {wsh_q[23:0], 8'h00};
                    a_q <= a_q + (wide ? 26'h000_0002 : 26'h000_0001);
                    if (beats_q > 3'h1) begin
                        beats_q <= beats_q - 3'h1;
                        state_q <= S_BEAT;
                    end else begin
                        prev_v_q <= 1'b1;
                        last_sp_q <= sp_q;
                        last_we_q <= we_q;
                        state_q <= S_FIN;
                    end
                end
                S_FIN: begin
                    o_busy <= 1'b0;
                    o_done <= dflag_q;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
            // beat count is fixed from the requested size and port width when the request is taken, before the first beat
            if (state_q == S_IDLE && i_req && !i_mode_req) begin
                if (i_size == `SDSI_SZ_LONG)
                    beats_q <= ((i_addr[28:26] == `SDSI_SP_BOOT)
                        | i_bus16[i_addr[28:26]]) ? 3'h2 : 3'h4;
                else if (i_size == `SDSI_SZ_WORD)
                    beats_q <= ((i_addr[28:26] == `SDSI_SP_BOOT)
                        | i_bus16[i_addr[28:26]]) ? 3'h1 : 3'h2;
                else
                    beats_q <= 3'h1;
            end
        end
    end
endmodule

// [inc/sdsi_regs.vh]
`ifndef SDSI_REGS_VH
`define SDSI_REGS_VH
// sdram command codes as {ras_n, cas_n, we_n}
`define SDSI_CMD_ACT 3'h3
`define SDSI_CMD_RD 3'h5
`define SDSI_CMD_WR 3'h4
`define SDSI_CMD_PRE 3'h2
`define SDSI_CMD_REF 3'h1
`define SDSI_CMD_MRS 3'h0
// normal space strobes: ras/cas idle, we_n is the rd/wr line
`define SDSI_CMD_NRD 3'h7
`define SDSI_CMD_NWR 3'h6
`define SDSI_INIT_REFS 4'h8
`define SDSI_MRS_BA 2'h0
`define SDSI_EMRS_BA 2'h1
`define SDSI_COL_MIN 5'h08
`define SDSI_ROW_MIN 5'h0b
`define SDSI_SP_BOOT 3'h0
`define SDSI_SP_AREA2 3'h2
`define SDSI_SP_AREA3 3'h3
`define SDSI_SP_NONE 3'h7
`define SDSI_SZ_BYTE 2'h0
`define SDSI_SZ_WORD 2'h1
`define SDSI_SZ_LONG 2'h2
`endif

// [sim/sdsi_ctrl_checker.sv]
`timescale 1ns/1ps
module sdsi_ctrl_checker (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_req,
    input wire i_mode_req,
    input wire i_mode_ext,
    input wire [28:0] i_addr,
    input wire i_sdram_area2,
    input wire [27:0] i_wait,
    input wire i_bank_active,
    input wire o_done,
    input wire o_busy,
    input wire [6:0] o_cs_n,
    input wire o_ras_n,
    input wire o_cas_n,
    input wire o_we_n,
    input wire o_cke,
    input wire [12:0] o_addr,
    input wire [1:0] o_ba,
    input wire o_dq_oe_n
);
    wire cs_any = ~&o_cs_n;
    wire c_mrs = cs_any && !o_ras_n && !o_cas_n && !o_we_n;
    wire c_ref = cs_any && !o_ras_n && !o_cas_n && o_we_n;
    wire c_pre = cs_any && !o_ras_n && o_cas_n && !o_we_n;
    wire c_acc = !o_cs_n[3] && o_ras_n && !o_cas_n;
    reg [11:0] mval_q;
    reg mext_q;
    reg [3:0] nref_q;
    reg [4:0] ncyc_q;
    // mode value latched at take, refreshes counted since the last precharge
    always @(posedge i_clk) begin
        if (i_rst) begin
            mval_q <= 12'h000;
            mext_q <= 1'b0;
            nref_q <= 4'h0;
            ncyc_q <= 5'h00;
        end else begin
            if (i_ce && !o_busy && i_mode_req) begin
                mval_q <= i_addr[11:0];
                mext_q <= i_mode_ext;
            end
            if (c_pre)
                nref_q <= 4'h0;
            else if (c_ref && nref_q != 4'hf)
                nref_q <= nref_q + 4'h1;
            ncyc_q <= o_cs_n[1] ? 5'h00 : ncyc_q + 5'h01;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_sd_areas: assert property ((!o_ras_n || !o_cas_n) |->
        (&o_cs_n[1:0] && &o_cs_n[6:4] && (o_cs_n[2] || i_sdram_area2)))
        else $error("sdram command outside sdram areas");
    a_cs_single: assert property ($onehot0(~o_cs_n) || o_cs_n == 7'h73)
        else $error("several chip selects active");
    a_ap_flag: assert property (c_acc && !i_bank_active |-> o_addr[10])
        else $error("auto-precharge flag missing");
    a_mrs_value: assert property (c_mrs |-> o_addr == {1'b0, mval_q} &&
        o_ba == {1'b0, mext_q}) else $error("mode value wrong");
    a_mrs_refs: assert property (c_mrs |-> nref_q == 4'h8)
        else $error("refresh count before mode set wrong");
    a_wr_drive: assert property (c_acc && !o_we_n |-> !o_dq_oe_n)
        else $error("write data not driven");
    a_wait_len: assert property ($rose(o_cs_n[1]) |->
        ncyc_q == {1'b0, i_wait[7:4]} + 5'h01) else $error("wait length wrong");
    a_unmapped_fin: assert property (i_ce && !o_busy && i_req && !i_mode_req &&
        i_addr[28:26] == 3'h7 |=> (o_busy && &o_cs_n) ##[1:3] (o_done && &o_cs_n))
        else $error("unmapped access misbehaves");
    c_mrs_seen: cover property (c_mrs);
    c_sref_seen: cover property (c_ref && !o_cke);
    c_pdn_seen: cover property (!o_cke && !o_busy && !c_ref);
    c_wait_seen: cover property ($rose(o_cs_n[1]) && ncyc_q > 5'h08);
endmodule
bind sdsi_ctrl sdsi_ctrl_checker sdsi_ctrl_checker_i (.*);

// [sim/sdsi_sdram_model.sv]
`timescale 1ns/1ps
module sdsi_sdram_model (
    input wire i_clk,
    input wire i_cs_n,
    input wire i_ras_n,
    input wire i_cas_n,
    input wire i_we_n,
    input wire [12:0] i_addr,
    input wire [1:0] i_ba,
    input wire [15:0] i_dq,
    input wire [1:0] i_dqm,
    input wire [3:0] i_cas_lat,
    input wire i_low_freq,
    output wire [15:0] o_dq,
    output reg [12:0] o_mrs_addr = 13'h0000,
    output reg [1:0] o_mrs_ba = 2'h0,
    output reg [31:0] o_ref_cnt = 32'h0000_0000,
    output reg [31:0] o_wr_cnt = 32'h0000_0000
);
    reg [15:0] mem [int];
    reg [12:0] row_q [0:3];
    reg [15:0] rd_q = 16'h0000;
    reg [15:0] pat_q = 16'ha5a5;
    reg [7:0] cnt_q = 8'hff;
    int key;
    // outside the read window the bus shows a toggling pattern
    // at low frequency the data is already settled one cycle earlier
    assign o_dq = (cnt_q + 8'h01 + {7'h00, i_low_freq} >= {4'h0, i_cas_lat} &&
        cnt_q <= {4'h0, i_cas_lat} + 8'h01) ? rd_q : pat_q;
    always @(posedge i_clk) begin
        pat_q <= ~pat_q;
        if (cnt_q != 8'hff)
            cnt_q <= cnt_q + 8'h01;
        key = {i_ba, row_q[i_ba], i_addr[9:0]};
        if (!i_cs_n) begin
            case ({i_ras_n, i_cas_n, i_we_n})
                3'b011: row_q[i_ba] <= i_addr;
                3'b101: begin
                    rd_q <= mem.exists(key) ? mem[key] : pat_q;
                    cnt_q <= 8'h00;
                end
                3'b100: begin
                    mem[key] = {i_dqm[1] ? mem[key][15:8] : i_dq[15:8],
                        i_dqm[0] ? mem[key][7:0] : i_dq[7:0]};
                    o_wr_cnt <= o_wr_cnt + 32'h1;
                end
                3'b001: o_ref_cnt <= o_ref_cnt + 32'h1;
                3'b000: begin
                    o_mrs_addr <= i_addr;
                    o_mrs_ba <= i_ba;
                end
                default: ;
            endcase
        end
    end
endmodule

// [sim/sdsi_ctrl_tb_top.sv]
`timescale 1ns/1ps
module sdsi_ctrl_tb_top;
    reg i_clk, i_rst, i_ce, i_req, i_mode_req, i_mode_ext, i_we, i_sdram_area2;
    reg i_sdram_area3, i_bank_active, i_refresh_en, i_self_refresh, i_low_freq, i_power_down;
    reg [1:0] i_size, i_row_sel, i_col_sel;
    reg [28:0] i_addr;
    reg [31:0] i_wdata, rnd, r0, w0;
    reg [6:0] i_bus16, seen;
    reg [27:0] i_wait;
    reg [2:0] i_idle_rws, i_idle_rwd, i_idle_rrs, i_idle_rrd, i_idle_wr;
    reg [15:0] i_ref_interval, nrm_dq;
    reg [3:0] i_trp, i_trc, i_trcd, i_cas_lat;
    reg [25:0] a [0:1];
    reg [7:0] bm [int];
    int fail_count, cmp_count, j, k;
    wire [31:0] o_rdata, m_ref, m_wr;
    wire o_done, o_busy, o_ras_n, o_cas_n, o_we_n, o_cke, o_dq_oe_n;
    wire [6:0] o_cs_n;
    wire [12:0] o_addr, m_mrs;
    wire [1:0] o_ba, o_dqm, m_ba;
    wire [15:0] o_dq, m_dq, i_dq;
    assign i_dq = (&o_cs_n[2:0] && &o_cs_n[6:4]) ? m_dq : nrm_dq;
    sdsi_ctrl sdsi_ctrl_i (.*);
    sdsi_sdram_model sdsi_sdram_model_i (.i_clk(i_clk), .i_cs_n(o_cs_n[3]), .i_ras_n(o_ras_n),
        .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_addr(o_addr), .i_ba(o_ba), .i_dq(o_dq),
        .i_dqm(o_dqm), .i_cas_lat(i_cas_lat), .o_dq(m_dq), .o_mrs_addr(m_mrs),
        .i_low_freq(i_low_freq), .o_mrs_ba(m_ba), .o_ref_cnt(m_ref), .o_wr_cnt(m_wr));
    always @(posedge i_clk) seen <= seen | ~o_cs_n;
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task acc(input m, input w, input [1:0] sz, input [28:0] ad, input [31:0] d);
        int n;
        for (n = 0; n < 500 && o_busy !== 1'b0; n++)
            @(negedge i_clk);
        if (o_busy !== 1'b0) begin
            fail_count++;
            stop_test;
        end
        i_mode_req = m;
        i_req = !m;
        i_we = w;
        i_size = sz;
        i_addr = ad;
        i_wdata = d;
        @(negedge i_clk);
        i_mode_req = 1'b0;
        i_req = 1'b0;
        for (n = 0; n < 3000 && o_done !== 1'b1; n++)
            @(negedge i_clk);
        if (o_done !== 1'b1) begin
            fail_count++;
            stop_test;
        end
    endtask
    task put(input [1:0] sz, input [25:0] ad, input [31:0] d);
        int i, n;
        n = 1 << sz;
        for (i = 0; i < n; i++)
            bm[ad + i] = d[8 * (n - 1 - i) +: 8];
    endtask
    function [31:0] get(input [1:0] sz, input [25:0] ad);
        int i;
        get = 32'h0000_0000;
        for (i = 0; i < (1 << sz); i++)
            get = {get[23:0], bm[ad + i]};
    endfunction
    task wr(input [1:0] sz, input [25:0] ad, input [31:0] d);
        acc(1'b0, 1'b1, sz, {3'h3, ad}, d);
        put(sz, ad, d);
    endtask
    task rd(input [1:0] sz, input [25:0] ad);
        acc(1'b0, 1'b0, sz, {3'h3, ad}, 32'h0000_0000);
        chk(o_rdata, get(sz, ad));
    endtask
    initial begin
        cmp_count = 0;
        fail_count = 0;
        rnd = 32'h3c34_7540;
        {i_rst, i_ce, i_sdram_area3} = 3'h7;
        {i_req, i_mode_req, i_mode_ext, i_we, i_sdram_area2, i_bank_active} = 6'h00;
        {i_refresh_en, i_self_refresh, i_low_freq, i_power_down} = 4'h0;
        {i_size, i_addr, i_wdata, i_wait, nrm_dq, seen} = '0;
        {i_idle_rws, i_idle_rwd, i_idle_rrs, i_idle_rrd, i_idle_wr} = 15'h0000;
        {i_row_sel, i_col_sel, i_bus16, i_ref_interval} = {2'h1, 2'h1, 7'h7f, 16'h0040};
        {i_trp, i_trc, i_trcd, i_cas_lat} = 16'h1212;
        repeat (4) @(negedge i_clk);
        i_rst = 1'b0;
        chk(o_cs_n, 7'h7f);
        chk({o_cke, o_busy, o_dqm}, 4'hb);
        // controller is configured before the settle time and mode write
        repeat (20000) @(negedge i_clk);
        for (k = 0; k < 3; k++) begin
            r0 = m_ref;
            w0 = m_wr;
            rnd = lfsr(rnd);
            i_mode_ext = k == 2;
            acc(1'b1, 1'b1, 2'h1, {3'h3, k == 1 ? 26'h3fc_5040 : 26'h3fc_5440}, rnd);
            chk(m_mrs, k == 1 ? 13'h0040 : 13'h0440);
            chk(m_ba, k == 2 ? 2'h1 : 2'h0);
            chk(m_ref - r0, 32'h8);
            chk(m_wr, w0);
        end
        for (k = 0; k < 12; k++) begin
            i_row_sel = k < 9 ? k % 3 : 2;
            i_col_sel = k < 9 ? k / 3 : 2;
            i_cas_lat = 4'h2 + k % 2;
            i_bank_active = k >= 9;
            bm.delete();
            for (j = 0; j < 2; j++) begin
                rnd = lfsr(rnd);
                a[j] = {4'h0, rnd[21:2], 2'h0};
                rnd = lfsr(rnd);
                wr(2'h2, a[j], rnd);
            end
            for (j = 0; j < 2; j++)
                rd(2'h2, a[j]);
        end
        rnd = lfsr(rnd);
        wr(2'h0, a[0] + 26'h1, rnd);
        rnd = lfsr(rnd);
        wr(2'h1, a[1] + 26'h2, rnd);
        rd(2'h2, a[0]);
        rd(2'h2, a[1]);
        i_bank_active = 1'b0;
        i_refresh_en = 1'b1;
        r0 = m_ref;
        repeat (300) @(negedge i_clk);
        chk(m_ref > r0, 1);
        i_self_refresh = 1'b1;
        repeat (40) @(negedge i_clk);
        chk(o_cke, 1'b0);
        i_self_refresh = 1'b0;
        repeat (40) @(negedge i_clk);
        chk(o_cke, 1'b1);
        rd(2'h2, a[0]);
        // refresh off so that no refresh lifts the clock enable in this window
        {i_power_down, i_low_freq, i_refresh_en} = 3'h6;
        repeat (20) @(negedge i_clk);
        chk(o_cke, 1'b0);
        rd(2'h2, a[1]);
        {i_power_down, i_low_freq} = 2'h0;
        for (k = 0; k < 8; k++) begin
            if (k == 3)
                continue;
            rnd = lfsr(rnd);
            i_wait = rnd[27:0];
            // unmapped access runs without idle gap, as the checker expects
            {i_idle_rws, i_idle_rwd, i_idle_rrs, i_idle_rrd, i_idle_wr} =
                k == 7 ? 15'h0000 : rnd[31:17];
            nrm_dq = rnd[15:0];
            seen = 7'h00;
            acc(1'b0, 1'b0, 2'h1, {k[2:0], 26'h000_0010}, 32'h0000_0000);
            chk(seen & 7'h77, k == 7 ? 7'h00 : 7'h01 << k);
            if (k != 7)
                chk(o_rdata, {16'h0000, nrm_dq});
        end
        $display("test sequence finished");
        stop_test;
    end
endmodule
